// [hw/bra_pkg.sv]
// Package: register map, command codes and field layout for the buffer block
// Assumes a 32-bit APB master with word-aligned register accesses
package bra_pkg;
    localparam int ADDR_W = 11;
    localparam int DATA_W = 8;
    localparam int RAM_DEPTH = 2048;
    // Register indexes, byte address is four times the index
    localparam logic [5:0] IDX_STATUS = 6'h00;
    localparam logic [5:0] IDX_CMD = 6'h01;
    localparam logic [5:0] IDX_PTR_HI = 6'h02;
    localparam logic [5:0] IDX_PTR_LO = 6'h03;
    localparam logic [5:0] IDX_DATA = 6'h04;
    localparam logic [5:0] IDX_MASK = 6'h05;
    localparam logic [5:0] IDX_NODE_ID = 6'h06;
    localparam logic [5:0] IDX_ARB_SETUP = 6'h07;
    // Status bits
    localparam int ST_TA = 0;
    localparam int ST_TMA = 1;
    localparam int ST_EXCESS_NAK_FLAG = 2;
    localparam int ST_IRQ = 3;
    // Pointer high fields
    localparam int PH_AUTOINC = 7;
    localparam int PH_HI_W = 3;
    // Arbitration setup bits
    localparam int AS_SLOW = 0;
    localparam int AS_LONG = 1;
    // Command word fields
    localparam logic [2:0] CMD_TX_EN = 3'h3;
    localparam logic [2:0] CMD_TX_DIS = 3'h1;
    localparam int CMD_PAGE_LSB = 3;
    localparam int CMD_OFS_BIT = 5;
    // Buffer layout
    localparam logic [8:0] BYTE_SID = 9'h000;
    localparam logic [8:0] BYTE_DID = 9'h001;
    localparam logic [8:0] BYTE_CNT = 9'h002;
    localparam logic [8:0] BYTE_LCNT = 9'h003;
    localparam logic [8:0] SHORT_END = 9'h0ff;
    localparam logic [8:0] LONG_END = 9'h1ff;
    localparam logic [7:0] BROADCAST_ID = 8'h00;
    localparam logic [7:0] NAK_LIMIT = 8'h80;
    localparam logic [7:0] NODE_ID_RST = 8'h01;
    localparam int NET_IN_W = 5;
    localparam int NI_TOKEN = 0;
    localparam int NI_ACK = 1;
    localparam int NI_NAK = 2;
    localparam int NI_NOISE = 3;
    localparam int NI_NONE = 4;
    typedef enum {S_IDLE, S_HDR, S_TOKEN, S_FBE, S_SEND, S_PACK} bra_tx_state_t;
endpackage

// [hw/bra_ram_if.sv]
// Interface: one port of the packet RAM between controller and memory
// Assumes a single clock shared by both ends
`timescale 1ns/1ps
interface bra_ram_if;
    logic en;
    logic we;
    logic [10:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport ctrl (output en, output we, output addr, output wdata, input rdata);
    modport mem (input en, input we, input addr, input wdata, output rdata);
endinterface

// [hw/bra_ram.sv]
// Packet RAM, single port, registered read data
// Assumes accesses arrive one per enabled cycle from the controller
`timescale 1ns/1ps
module bra_ram #(
    parameter int DEPTH = 2048
) (
    input wire logic pclk,
    bra_ram_if.mem port
);
    logic [7:0] mem_q [DEPTH];
    logic [7:0] rdata_q;

    always_ff @(posedge pclk) begin
        if (port.en && port.we) begin
            mem_q[port.addr] <= port.wdata;
        end
    end

    always_ff @(posedge pclk) begin
        if (port.en && !port.we) begin
            rdata_q <= mem_q[port.addr];
        end
    end

    assign port.rdata = rdata_q;
endmodule // bra_ram

// [hw/bra_buffer.sv]
// Buffer RAM pointer access over APB and transmit sequencing
// Assumes network inputs are asynchronous pins; one pclk domain
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
// What this block does
// - Low pointer write latches address; high byte written beforehand.
// - Loading pointer fetches that RAM byte into the data register.
// - Auto-increment advances pointer per data access and, on data reads only, prefetches next byte.
// - Slow arbitration bit halves the RAM arbitration rate.
// - Pointer value is readable after a burst.
// - RAM holds four 512-byte pages chosen by two-bit page number.
// - Offset bit 5 adds 256; start is page*512 plus offset*256.
// - No page boundary check on receive; host reserves 512-byte pages.
// - With long packets, byte 2 zero means long, else short.
// - Layout: source, destination, 256-N count, or zero then 512-N.
// - Own node ID replaces buffer byte 0 on transmit.
// - Transmit enable only with flag set; clears available and acked flags.
// - Non-broadcast sends free-buffer enquiry at token before packet.
// - Enquiry ACK sends packet; available set, acked only on packet ACK.
// - Enquiry NAK passes token, retries; many NAKs raise excess flag.
// - No enquiry response sets available flag, acked stays zero.
// - Noise after enquiry: token not passed.
// - Disable command cancels at next token, sets available only.
// - Transmit completion raises interrupt when mask permits.
module bra_buffer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [bra_pkg::NET_IN_W-1:0] net_in,
    output logic free_buffer_enquiry,
    output logic pass_token,
    output logic [7:0] tx_data,
    output logic tx_valid,
    output logic tx_last,
    input wire logic tx_ready,
    output logic irq
);
    import bra_pkg::*;

    bra_ram_if ram ();
    bra_ram #(.DEPTH(RAM_DEPTH)) u_ram (.pclk(pclk), .port(ram));

    // Register bus decode
    logic acc, wr, rd, mapped;
    logic [5:0] idx;
    assign acc = psel && penable;
    assign idx = paddr[7:2];
    assign mapped = (paddr[1:0] == 2'h0) && (idx <= IDX_ARB_SETUP);
    assign wr = acc && pwrite && mapped;
    assign rd = acc && !pwrite && mapped;
    assign pready = 1'b1;
    assign pslverr = acc && !mapped;

    // Network pin synchronisers
    logic [NET_IN_W-1:0] ns1_q, ns2_q, ns3_q, net_ev;
    genvar g;
    generate
        for (g = 0; g < NET_IN_W; g++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    ns1_q[g] <= 1'b0;
                    ns2_q[g] <= 1'b0;
                    ns3_q[g] <= 1'b0;
                end else begin
                    ns1_q[g] <= net_in[g];
                    ns2_q[g] <= ns1_q[g];
                    ns3_q[g] <= ns2_q[g];
                end
            end
            assign net_ev[g] = ns2_q[g] && !ns3_q[g];
        end
    endgenerate

    // Software registers
    logic [7:0] mask_q, node_id_q, setup_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_q <= 8'h00;
            node_id_q <= NODE_ID_RST;
            setup_q <= 8'h00;
        end else if (wr) begin
            if (idx == IDX_MASK) mask_q <= pwdata[7:0];
            if (idx == IDX_NODE_ID) node_id_q <= pwdata[7:0];
            if (idx == IDX_ARB_SETUP) setup_q <= pwdata[7:0];
        end
    end

    logic arb_tog_q, arb_en;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) arb_tog_q <= 1'b0;
        else arb_tog_q <= !arb_tog_q;
    end
    assign arb_en = !setup_q[AS_SLOW] || arb_tog_q;

    // Host pointer side
    logic [ADDR_W-1:0] ptr_q;
    logic [PH_HI_W-1:0] ptr_hi_q;
    logic autoinc_q, host_rd_pend_q, host_wr_pend_q, host_got_q;
    logic [7:0] data_q, wbuf_q;
    logic host_gnt, tx_gnt, tx_got_q, tx_rd_q;
    logic [ADDR_W-1:0] tx_addr_q;
    logic data_rd, data_wr;
    assign data_rd = rd && (idx == IDX_DATA);
    assign data_wr = wr && (idx == IDX_DATA);
    assign host_gnt = arb_en && (host_rd_pend_q || host_wr_pend_q);
    assign tx_gnt = arb_en && tx_rd_q && !host_gnt;

    assign ram.en = host_gnt || tx_gnt;
    assign ram.we = host_gnt && host_wr_pend_q;
    assign ram.addr = host_gnt ? ptr_q : tx_addr_q;
    assign ram.wdata = wbuf_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_q <= '0;
            ptr_hi_q <= '0;
            autoinc_q <= 1'b0;
        end else if (wr && idx == IDX_PTR_HI) begin
            ptr_hi_q <= pwdata[PH_HI_W-1:0];
            autoinc_q <= pwdata[PH_AUTOINC];
        end else if (wr && idx == IDX_PTR_LO) begin
            ptr_q <= {ptr_hi_q, pwdata[7:0]};
        end else if (autoinc_q && (data_rd || (host_gnt && host_wr_pend_q))) begin
            ptr_q <= ptr_q + 11'h001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_rd_pend_q <= 1'b0;
            host_wr_pend_q <= 1'b0;
            wbuf_q <= 8'h00;
        end else if (data_wr) begin
            host_wr_pend_q <= 1'b1;
            host_rd_pend_q <= 1'b0;
            wbuf_q <= pwdata[7:0];
        end else if ((wr && idx == IDX_PTR_LO) || (data_rd && autoinc_q)) begin
            host_rd_pend_q <= 1'b1;
        end else if (host_gnt) begin
            host_rd_pend_q <= 1'b0;
            host_wr_pend_q <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            host_got_q <= 1'b0;
            tx_got_q <= 1'b0;
            data_q <= 8'h00;
        end else begin
            host_got_q <= host_gnt && !host_wr_pend_q;
            tx_got_q <= tx_gnt;
            if (host_got_q) data_q <= ram.rdata;
        end
    end

    // Transmit sequencer
    bra_tx_state_t st_q;
    logic ta_q, tma_q, excess_nak_flag_q, dis_pend_q, long_q;
    logic [ADDR_W-1:0] base_q;
    logic [8:0] tidx_q, start_q, end_q;
    logic [7:0] dest_q, nak_cnt_q;
    logic tx_cmd, dis_cmd, tok, fbe_sent_q;
    assign tx_cmd = wr && idx == IDX_CMD && pwdata[2:0] == CMD_TX_EN && ta_q;
    assign dis_cmd = wr && idx == IDX_CMD && pwdata[2:0] == CMD_TX_DIS;
    assign tok = net_ev[NI_TOKEN];

    function automatic logic [8:0] next_idx(input logic [8:0] i, input logic lg,
                                            input logic [8:0] s);
        logic [8:0] r;
        r = i + 9'h001;
        if (i == BYTE_CNT && !lg) r = s;
        if (i == BYTE_LCNT && lg) r = s;
        return r;
    endfunction

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= S_IDLE;
            base_q <= '0;
            tidx_q <= '0;
            start_q <= '0;
            end_q <= '0;
            dest_q <= 8'h00;
            long_q <= 1'b0;
            tx_rd_q <= 1'b0;
            tx_addr_q <= '0;
            tx_data <= 8'h00;
            tx_valid <= 1'b0;
            tx_last <= 1'b0;
            fbe_sent_q <= 1'b0;
        end else begin
            case (st_q)
                S_IDLE: begin
                    if (tx_cmd) begin
                        base_q <= {pwdata[CMD_PAGE_LSB+1:CMD_PAGE_LSB],
                                   pwdata[CMD_OFS_BIT], 8'h00};
                        tidx_q <= BYTE_DID;
                        tx_addr_q <= {pwdata[CMD_PAGE_LSB+1:CMD_PAGE_LSB],
                                      pwdata[CMD_OFS_BIT], 8'h00} + {2'b00, BYTE_DID};
                        tx_rd_q <= 1'b1;
                        long_q <= 1'b0;
                        st_q <= S_HDR;
                    end
                end
                S_HDR: begin
                    if (tx_gnt) tx_rd_q <= 1'b0;
                    if (tx_got_q) begin
                        if (tidx_q == BYTE_DID) begin
                            dest_q <= ram.rdata;
                            tidx_q <= BYTE_CNT;
                            tx_addr_q <= base_q + {2'b00, BYTE_CNT};
                            tx_rd_q <= 1'b1;
                        // With long mode set, zero count byte marks long packet
                        end else if (tidx_q == BYTE_CNT && setup_q[AS_LONG] &&
                                     ram.rdata == 8'h00) begin
                            long_q <= 1'b1;
                            tidx_q <= BYTE_LCNT;
                            tx_addr_q <= base_q + {2'b00, BYTE_LCNT};
                            tx_rd_q <= 1'b1;
                        end else begin
                            start_q <= {1'b0, ram.rdata};
                            end_q <= long_q ? LONG_END : SHORT_END;
                            st_q <= S_TOKEN;
                        end
                    end
                end
                S_TOKEN: begin
                    if (tok && !dis_pend_q) begin
                        tidx_q <= BYTE_SID;
                        if (dest_q != BROADCAST_ID) begin
                            fbe_sent_q <= 1'b1;
                            st_q <= S_FBE;
                        end else begin
                            tx_addr_q <= base_q;
                            tx_rd_q <= 1'b1;
                            st_q <= S_SEND;
                        end
                    end else if (tok) begin
                        st_q <= S_IDLE;
                    end
                end
                S_FBE: begin
                    fbe_sent_q <= 1'b0;
                    if (net_ev[NI_ACK]) begin
                        tx_addr_q <= base_q;
                        tx_rd_q <= 1'b1;
                        st_q <= S_SEND;
                    end else if (net_ev[NI_NAK] || net_ev[NI_NOISE]) begin
                        st_q <= S_TOKEN;
                    end else if (net_ev[NI_NONE]) begin
                        st_q <= S_IDLE;
                    end
                end
                S_SEND: begin
                    if (tx_gnt) tx_rd_q <= 1'b0;
                    if (tx_got_q) begin
                        tx_data <= (tidx_q == BYTE_SID) ? node_id_q : ram.rdata;
                        tx_valid <= 1'b1;
                        tx_last <= (tidx_q == end_q);
                    end else if (tx_valid && tx_ready) begin
                        tx_valid <= 1'b0;
                        tx_last <= 1'b0;
                        if (tx_last) begin
                            st_q <= (dest_q == BROADCAST_ID) ? S_IDLE : S_PACK;
                        end else begin
                            tidx_q <= next_idx(tidx_q, long_q, start_q);
                            tx_addr_q <= base_q + {2'b00, next_idx(tidx_q, long_q, start_q)};
                            tx_rd_q <= 1'b1;
                        end
                    end
                end
                S_PACK: begin
                    if (net_ev[NI_ACK] || net_ev[NI_NONE]) st_q <= S_IDLE;
                end
                default: st_q <= S_IDLE;
            endcase
        end
    end

    assign free_buffer_enquiry = fbe_sent_q;
    // Token pass events
    always_comb begin
        pass_token = 1'b0;
        if (st_q == S_FBE && (net_ev[NI_NAK] || net_ev[NI_NONE])) pass_token = 1'b1;
        if (st_q == S_FBE && net_ev[NI_NOISE]) pass_token = 1'b0;
        if (st_q == S_PACK && (net_ev[NI_ACK] || net_ev[NI_NONE])) pass_token = 1'b1;
        if (st_q == S_TOKEN && tok && dis_pend_q) pass_token = 1'b1;
    end

    // Status flags, set wins over clear, except completion clears a pending disable
    logic done_ok, done_any;
    assign done_ok = st_q == S_PACK && net_ev[NI_ACK];
    assign done_any = (st_q == S_PACK && (net_ev[NI_ACK] || net_ev[NI_NONE])) ||
                      (st_q == S_FBE && net_ev[NI_NONE]) ||
                      (st_q == S_TOKEN && tok && dis_pend_q) ||
                      (st_q == S_SEND && tx_valid && tx_ready && tx_last &&
                       dest_q == BROADCAST_ID);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ta_q <= 1'b1;
            tma_q <= 1'b0;
            excess_nak_flag_q <= 1'b0;
            dis_pend_q <= 1'b0;
            nak_cnt_q <= 8'h00;
        end else begin
            if (tx_cmd) begin
                ta_q <= 1'b0;
                tma_q <= 1'b0;
                excess_nak_flag_q <= 1'b0;
                nak_cnt_q <= 8'h00;
                dis_pend_q <= 1'b0;
            end
            if (dis_cmd && !ta_q) dis_pend_q <= 1'b1;
            if (done_any) begin
                ta_q <= 1'b1;
                dis_pend_q <= 1'b0;
            end
            if (done_ok) tma_q <= 1'b1;
            if (st_q == S_FBE && net_ev[NI_NAK]) begin
                nak_cnt_q <= nak_cnt_q + 8'h01;
                if (nak_cnt_q == NAK_LIMIT - 8'h01) excess_nak_flag_q <= 1'b1;
            end
        end
    end

    assign irq = (ta_q && mask_q[ST_TA]) || (excess_nak_flag_q && mask_q[ST_EXCESS_NAK_FLAG]);

    // Register read mux
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd) begin
            case (idx)
                IDX_STATUS: prdata[3:0] = {irq, excess_nak_flag_q, tma_q, ta_q};
                IDX_PTR_HI: prdata[7:0] = {autoinc_q, 4'h0, ptr_q[10:8]};
                IDX_PTR_LO: prdata[7:0] = ptr_q[7:0];
                IDX_DATA: prdata[7:0] = data_q;
                IDX_MASK: prdata[7:0] = mask_q;
                IDX_NODE_ID: prdata[7:0] = node_id_q;
                IDX_ARB_SETUP: prdata[7:0] = setup_q;
                default: prdata = 32'h0000_0000;
            endcase
        end
    end

    ptr_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && idx == IDX_PTR_LO |=> ptr_q == {ptr_hi_q, $past(pwdata[7:0])})
        else $error("pointer not loaded from low write");
    fetch_load_a: assert property (@(posedge pclk) disable iff (!presetn)
        wr && idx == IDX_PTR_LO && !setup_q[AS_SLOW] |=> ##1 host_got_q)
        else $error("pointer load did not fetch");
    auto_step_a: assert property (@(posedge pclk) disable iff (!presetn)
        data_rd && autoinc_q |=> ptr_q == $past(ptr_q) + 11'h001 && host_rd_pend_q)
        else $error("auto increment missing");
    slow_arb_a: assert property (@(posedge pclk) disable iff (!presetn)
        setup_q[AS_SLOW] && ram.en |=> !ram.en)
        else $error("slow arbitration back to back");
    tx_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
        tx_cmd |=> !ta_q && !tma_q)
        else $error("enable did not clear flags");
    enq_first_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == S_TOKEN && tok && !dis_pend_q && dest_q != BROADCAST_ID
        |=> free_buffer_enquiry ##1 !free_buffer_enquiry)
        else $error("enquiry not sent");
    ack_flag_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == S_FBE && net_ev[NI_NONE] |=> ta_q && !tma_q)
        else $error("no response flags wrong");
    noise_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == S_FBE && net_ev[NI_NOISE] |-> !pass_token)
        else $error("token passed on noise");
    cancel_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == S_TOKEN && tok && dis_pend_q |=> ta_q && !tma_q && st_q == S_IDLE)
        else $error("disable did not cancel");
    own_id_a: assert property (@(posedge pclk) disable iff (!presetn)
        st_q == S_SEND && tx_got_q && tidx_q == BYTE_SID |=> tx_data == node_id_q)
        else $error("byte 0 not own id");
endmodule // bra_buffer

// [verification/bra_net_model.sv]
// Network-side model: token and reply events, byte sink with stalls
// Assumes event pins are seen on their rising edge, held for three cycles
`timescale 1ns/1ps
module bra_net_model (
    input wire logic pclk,
    input wire logic free_buffer_enquiry,
    input wire logic pass_token,
    input wire logic [7:0] tx_data,
    input wire logic tx_valid,
    input wire logic tx_last,
    output logic tx_ready,
    output logic [4:0] net_in
);
    logic [7:0] got[$];
    int fbe_n = 0;
    int pass_n = 0;
    int reply = 1;
    int pkt = 1;
    bit slow = 0;
    logic [1:0] ph = 2'b00;
    initial net_in = 5'h00;
    initial tx_ready = 1'b0;
    // Negative index means no event at all
    task automatic pulse(input int i);
        if (i >= 0) begin
            @(posedge pclk);
            net_in[i] <= 1'b1;
            repeat (3) @(posedge pclk);
            net_in[i] <= 1'b0;
        end
    endtask
    always @(posedge pclk) begin
        ph <= ph + 2'd1;
        tx_ready <= !slow || ph[1];
        fbe_n <= fbe_n + int'(free_buffer_enquiry);
        pass_n <= pass_n + int'(pass_token);
        if (tx_valid && tx_ready) got.push_back(tx_data);
    end
    always begin
        @(posedge pclk);
        if (free_buffer_enquiry === 1'b1) pulse(reply);
        else if (tx_valid && tx_ready && tx_last) pulse(pkt);
    end
endmodule // bra_net_model

// [verification/buffer_ram_access_and_transmit_bench.sv]
// Bench: APB host, random RAM bursts and transmit outcomes
// Assumes bra_net_model on the network side, 125 MHz pclk
`timescale 1ns/1ps
module buffer_ram_access_and_transmit_bench;
    import bra_pkg::*;
    logic pclk = 0;
    logic presetn = 0;
    logic psel = 0;
    logic penable = 0;
    logic pwrite = 0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, v;
    logic pready, pslverr, fbe, pass, tx_valid, tx_last, tx_ready, irq, serr;
    logic [7:0] tx_data, nid;
    logic [4:0] net_in;
    int seed = 32'h5360;
    int err_count = 0;
    int total_checks = 0;
    always #4 pclk = ~pclk;
    bra_buffer u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .net_in(net_in), .free_buffer_enquiry(fbe), .pass_token(pass),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
        .irq(irq));
    bra_net_model u_net (.pclk(pclk), .free_buffer_enquiry(fbe), .pass_token(pass),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last), .tx_ready(tx_ready),
        .net_in(net_in));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    task automatic hang;
        err_count++;
        finish_test();
    endtask
    task automatic apb(input logic w, input logic [5:0] idx, input logic [31:0] wd);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) hang();
        v = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (5) @(posedge pclk);
    endtask
    // high byte first, idle before data
    task automatic setptr(input logic [10:0] a);
        apb(1'b1, IDX_PTR_HI, {24'h0, 5'h10, a[10:8]});
        apb(1'b1, IDX_PTR_LO, {24'h0, a[7:0]});
    endtask
    task automatic tx_run(input bit lng, input int n, fr, pr, input logic [7:0] dst);
        logic [7:0] q[$];
        logic [7:0] d;
        int pg, f, s, f0, p0, k;
        pg = {$random(seed)} % 4;
        f = lng ? 0 : {$random(seed)} % 2;
        s = lng ? 512 - n : 256 - n;
        u_net.slow = $random(seed);
        u_net.reply = fr;
        u_net.pkt = pr;
        // random arbitration rate, long mode random for short packets
        apb(1'b1, IDX_ARB_SETUP, {30'h0, lng | 1'($random(seed)), 1'($random(seed))});
        // header, then data up to the buffer's top
        setptr(11'(pg * 512 + f * 256 + 1));
        apb(1'b1, IDX_DATA, {24'h0, dst});
        q = '{nid, dst, lng ? 8'h00 : 8'(s)};
        apb(1'b1, IDX_DATA, {24'h0, q[2]});
        if (lng) q.push_back(8'(s));
        if (lng) apb(1'b1, IDX_DATA, 32'(s));
        setptr(11'(pg * 512 + f * 256 + s));
        repeat (n) begin
            d = $random(seed);
            q.push_back(d);
            apb(1'b1, IDX_DATA, {24'h0, d});
        end
        u_net.got.delete();
        f0 = u_net.fbe_n;
        p0 = u_net.pass_n;
        apb(1'b1, IDX_CMD, 32'(CMD_TX_EN) | 32'(pg << CMD_PAGE_LSB) | 32'(f << CMD_OFS_BIT));
        apb(1'b0, IDX_STATUS, 32'h0);
        check("flags_cleared", v[1:0], 0);
        check("irq_low", irq, 0);
        repeat (fr == NI_NAK ? 128 : 1) begin
            u_net.pulse(NI_TOKEN);
            repeat (12) @(posedge pclk);
        end
        if (fr == NI_NAK || fr == NI_NOISE) begin
            apb(1'b0, IDX_STATUS, 32'h0);
            check("pending", v[ST_TA], 0);
            check("excess_nak", v[ST_EXCESS_NAK_FLAG], fr == NI_NAK);
            check("passes", u_net.pass_n - p0, fr == NI_NAK ? 128 : 0);
            if (fr == NI_NOISE) apb(1'b1, IDX_CMD, 32'(CMD_TX_DIS));
            u_net.reply = NI_NONE;
            u_net.pulse(NI_TOKEN);
        end
        k = 0;
        do begin
            apb(1'b0, IDX_STATUS, 32'h0);
            k++;
        end while (v[ST_TA] !== 1'b1 && k < 1000);
        if (v[ST_TA] !== 1'b1) hang();
        if (dst != 0) check("acked", v[ST_TMA], fr == NI_ACK && pr == NI_ACK);
        check("irq_high", irq, 1);
        check("enquiries", u_net.fbe_n - f0, dst == 0 ? 0 : fr == NI_NAK ? 129 : 1);
        if (fr != NI_ACK) q.delete();
        check("byte_count", u_net.got.size(), q.size());
        foreach (q[i]) check("tx_byte", u_net.got[i], q[i]);
    endtask
    initial begin
        logic [7:0] d[8];
        logic [10:0] b;
        logic [2:0] h;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, IDX_STATUS, 32'h0);
        check("status_reset", v, 32'h1);
        apb(1'b0, 6'h08, 32'h0);
        check("unmapped", serr, 1);
        for (int m = 0; m < 2; m++) begin
            b = 11'({$random(seed)} % 2040);
            apb(1'b1, IDX_ARB_SETUP, 32'(m));
            setptr(b);
            foreach (d[i]) begin
                d[i] = $random(seed);
                apb(1'b1, IDX_DATA, {24'h0, d[i]});
            end
            apb(1'b0, IDX_PTR_HI, 32'h0);
            h = v[2:0];
            apb(1'b0, IDX_PTR_LO, 32'h0);
            check("ptr_after", {h, v[7:0]}, b + 11'd8);
            setptr(b);
            foreach (d[i]) begin
                apb(1'b0, IDX_DATA, 32'h0);
                check("ram_byte", v[7:0], d[i]);
            end
        end
        nid = 8'($random(seed)) | 8'h01;
        apb(1'b1, IDX_NODE_ID, {24'h0, nid});
        apb(1'b1, IDX_MASK, 32'h1);
        tx_run(0, 1, NI_ACK, NI_ACK, 8'h05);
        tx_run(0, 253, NI_ACK, NI_NONE, 8'h7a);
        tx_run(1, 257, NI_ACK, NI_ACK, 8'hff);
        tx_run(1, 508, NI_ACK, NI_ACK, 8'h33);
        tx_run(0, 2, NI_NONE, NI_ACK, 8'h21);
        tx_run(0, 2, NI_NAK, NI_ACK, 8'h44);
        tx_run(0, 2, NI_NOISE, NI_ACK, 8'h45);
        tx_run(0, 4, NI_ACK, -1, 8'h00);
        finish_test();
    end
endmodule // buffer_ram_access_and_transmit_bench
